//--- design/aqtsq_pkg.sv
// constants, types and register map of the acquisition trigger sequencer
// Function
// [R1] type 1 analog, 2 digital A, 3 digital B
// [R2] zero pretrigger: start trigger begins the total scans
// [R3] posttrigger start from analog or digital A; digital B illegal
// [R4] both counts nonzero: pretrigger scans first, trigger starts posttrigger
// [R5] pretrigger acquisition runs until the stop trigger
// [R6] software start: the software strobe begins scanning
// [R7] start and stop enabled: hardware start, then await stop
// [R8] start from digital B or analog, stop from digital A or analog
// [R9] pretrigger full, no stop: drop oldest scans, keep latest
// [R10] analog channel trigger, posttrigger: channel first in scan list
// [R11] analog channel trigger, pretrigger: single-channel scan list only; arming does not check chans_r
// [R12] digital B start, analog stop: dedicated input unless one channel; the code drives the select from the COMP register bit only
// [R13] type 4: external logic gate pauses and resumes scan clock
// [R14] shared clocks: gate low halts mid-scan, gate high resumes there
// [R15] type 5: analog comparator gates the scan clock
// [R16] type 6: comparator events drive a general-purpose output
// [R17] types 1, 5, 6 share the comparator; last enabled wins
// [R18] type 5 replaces any type 4 gating setup
// [R19] condition 1 fires on rising edge or rising slope
// [R20] fixed-pin parts take start then stop on one input
// [R21] after stop, collect total minus pretrigger scans, then end
package aqtsq_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_START    = 8'h04;
   localparam logic [7:0] ADDR_STOP     = 8'h08;
   localparam logic [7:0] ADDR_GATE     = 8'h0C;
   localparam logic [7:0] ADDR_COMP     = 8'h10;
   localparam logic [7:0] ADDR_TOTAL    = 8'h14;
   localparam logic [7:0] ADDR_PRE      = 8'h18;
   localparam logic [7:0] ADDR_TIMING   = 8'h1C;
   localparam logic [7:0] ADDR_STATUS   = 8'h20;
   localparam logic [7:0] ADDR_SCANCNT  = 8'h24;
   localparam logic [7:0] ADDR_DISCARD  = 8'h28;
   localparam logic [7:0] ADDR_PINCFG   = 8'h2C;

   // field positions
   localparam int CTRL_ARM_BIT     = 0;
   localparam int CTRL_ABORT_BIT   = 1;
   localparam int TYPE_LSB         = 0;
   localparam int COND_LSB         = 4;
   localparam int COMP_OUT_EN_BIT  = 0;
   localparam int COMP_LEVEL_LSB   = 8;
   localparam int COMP_WINDOW_LSB  = 16;
   localparam int COMP_DEDIC_BIT   = 24;
   localparam int TIM_CHANS_LSB    = 16;
   localparam int STAT_ILLEGAL_BIT = 4;
   localparam int STAT_DONE_BIT    = 5;
   localparam int STAT_OWNER_LSB   = 8;
   localparam int PIN_SINGLE_BIT   = 0;

   // trigger type codes
   localparam logic [2:0] TT_NONE   = 3'h0;
   localparam logic [2:0] TT_ANALOG = 3'h1;
   localparam logic [2:0] TT_DIG_A  = 3'h2;
   localparam logic [2:0] TT_DIG_B  = 3'h3;
   localparam logic [2:0] TT_DGATE  = 3'h4;
   localparam logic [2:0] TT_AGATE  = 3'h5;
   localparam logic [2:0] TT_ACOUT  = 3'h6;

   // trigger conditions
   localparam logic [1:0] COND_RISE = 2'h1;
   localparam logic [1:0] COND_FALL = 2'h2;

   // reset values
   localparam logic [15:0] RST_CHAN_INTERVAL = 16'h0004;
   localparam logic [7:0]  RST_CHANS         = 8'h01;
   localparam logic [23:0] RST_TOTAL         = 24'h00_03E8;
   localparam logic [23:0] RST_PRE           = 24'h00_0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_START,
      ST_PRE,
      ST_POST,
      ST_DONE
   } aqtsq_state_t;

endpackage

//--- design/aqtsq_edge_det.sv
// per-source edge detector with programmable polarity
module aqtsq_edge_det
   import aqtsq_pkg::*;
#(
   parameter int N = 3
) (
   input  wire logic           clk_sys,
   input  wire logic           rst_n,
   input  wire logic [N-1:0]   sigIn,
   input  wire logic [2*N-1:0] condIn,
   output logic      [N-1:0]   edgeOut
);

   logic [N-1:0] prev_r;

   for (genvar i = 0; i < N; i++) begin : g_src
      // last sample of each source
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            prev_r[i] <= 1'b0;
         end else begin
            prev_r[i] <= sigIn[i];
         end
      end

      // falling only on explicit request; any other code fires on rising
      always_comb begin
         if (condIn[2*i +: 2] == COND_FALL) begin
            edgeOut[i] = prev_r[i] & ~sigIn[i];
         end else begin
            edgeOut[i] = ~prev_r[i] & sigIn[i]; // [R19]
         end
      end
   end

endmodule // aqtsq_edge_det

//--- design/aqtsq_sequencer.sv
// acquisition trigger sequencer top with apb register file
module aqtsq_sequencer
   import aqtsq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        startTriggerPin,
   input  wire logic        stopTriggerPin,
   input  wire logic        externalTriggerPin,
   input  wire logic        externalScanGateInput,
   input  wire logic        analogCompareIn,
   output logic      [7:0]  compLevel,
   output logic      [7:0]  compWindow,
   output logic             dedicatedTriggerInputSel,
   output logic             comparatorEventOutput,
   output logic             channelClockPulse,
   output logic             scanClockPulse,
   output logic             acquiring,
   output logic             acqDone
);

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic [2:0]   startType_r, stopType_r, gateType_r, compOwner_r;
   logic [1:0]   startCond_r, stopCond_r, compOutCond_r, compCond_r;
   logic [7:0]   compLevel_r, compWindow_r, chans_r, chanIdx_r;
   logic [15:0]  chanInterval_r, chanDiv_r;
   logic [23:0]  total_r, pre_r, preHeld_r, postCnt_r, postTarget_r, scanCnt_r, discard_r;
   logic         compOutEn_r, dedicSel_r, singlePin_r, illegal_r;
   logic         chanPulse_r, scanPulse_r, compOut_r;
   aqtsq_state_t state_r;

   logic         wrEn, addrHit, armWr, abortWr, running, gateOpen, chanTick, scanTick;
   logic         preFull, startLegalPost, stopLegal, startLegalHw, pretrig, cfgIllegal;
   logic         digA, digB, digStart, digStop, compEv, startEv, stopEv;
   logic [2:0]   edges;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, error on unmapped offsets

   assign wrEn    = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addrHit;
   assign armWr   = wrEn & (paddr == ADDR_CTRL) & pwdata[CTRL_ARM_BIT];
   assign abortWr = wrEn & (paddr == ADDR_CTRL) & pwdata[CTRL_ABORT_BIT];

   // address decode and read mux
   always_comb begin
      prdata  = 32'h0000_0000;
      addrHit = 1'b1;
      if (paddr == ADDR_CTRL) begin
         prdata = 32'h0000_0000;
      end else if (paddr == ADDR_START) begin
         prdata = {26'h000_0000, startCond_r, 1'b0, startType_r};
      end else if (paddr == ADDR_STOP) begin
         prdata = {26'h000_0000, stopCond_r, 1'b0, stopType_r};
      end else if (paddr == ADDR_GATE) begin
         prdata = {29'h0000_0000, gateType_r};
      end else if (paddr == ADDR_COMP) begin
         prdata = {7'h00, dedicSel_r, compWindow_r, compLevel_r,
                   2'h0, compOutCond_r, 3'h0, compOutEn_r};
      end else if (paddr == ADDR_TOTAL) begin
         prdata = {8'h00, total_r};
      end else if (paddr == ADDR_PRE) begin
         prdata = {8'h00, pre_r};
      end else if (paddr == ADDR_TIMING) begin
         prdata = {8'h00, chans_r, chanInterval_r};
      end else if (paddr == ADDR_STATUS) begin
         prdata = {21'h00_0000, compOwner_r, 2'h0, acqDone, illegal_r, 1'b0, state_r};
      end else if (paddr == ADDR_SCANCNT) begin
         prdata = {8'h00, scanCnt_r};
      end else if (paddr == ADDR_DISCARD) begin
         prdata = {8'h00, discard_r};
      end else if (paddr == ADDR_PINCFG) begin
         prdata = {31'h0000_0000, singlePin_r};
      end else begin
         addrHit = 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         startType_r    <= TT_NONE;
         startCond_r    <= COND_RISE;
         stopType_r     <= TT_NONE;
         stopCond_r     <= COND_RISE;
         gateType_r     <= TT_NONE;
         compOutEn_r    <= 1'b0;
         compOutCond_r  <= COND_RISE;
         compLevel_r    <= 8'h00;
         compWindow_r   <= 8'h00;
         dedicSel_r     <= 1'b0;
         total_r        <= RST_TOTAL;
         pre_r          <= RST_PRE;
         chanInterval_r <= RST_CHAN_INTERVAL;
         chans_r        <= RST_CHANS;
         singlePin_r    <= 1'b0;
      end else if (wrEn) begin
         if (paddr == ADDR_START) begin
            startType_r <= pwdata[TYPE_LSB +: 3];
            startCond_r <= pwdata[COND_LSB +: 2];
         end else if (paddr == ADDR_STOP) begin
            stopType_r <= pwdata[TYPE_LSB +: 3];
            stopCond_r <= pwdata[COND_LSB +: 2];
         end else if (paddr == ADDR_GATE) begin
            // one gate field: writing type 5 overwrites a type 4 setup
            gateType_r <= pwdata[TYPE_LSB +: 3]; // [R18]
         end else if (paddr == ADDR_COMP) begin
            compOutEn_r   <= pwdata[COMP_OUT_EN_BIT];
            compOutCond_r <= pwdata[COND_LSB +: 2];
            compLevel_r   <= pwdata[COMP_LEVEL_LSB +: 8];
            compWindow_r  <= pwdata[COMP_WINDOW_LSB +: 8];
            dedicSel_r    <= pwdata[COMP_DEDIC_BIT];
         end else if (paddr == ADDR_TOTAL) begin
            total_r <= pwdata[23:0];
         end else if (paddr == ADDR_PRE) begin
            pre_r <= pwdata[23:0];
         end else if (paddr == ADDR_TIMING) begin
            chanInterval_r <= pwdata[15:0];
            chans_r        <= pwdata[TIM_CHANS_LSB +: 8];
         end else if (paddr == ADDR_PINCFG) begin
            singlePin_r <= pwdata[PIN_SINGLE_BIT];
         end
      end
   end

   // comparator ownership: the last user enabled sets its polarity
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         compOwner_r <= TT_NONE;
         compCond_r  <= COND_RISE;
      end else if (wrEn) begin
         if ((paddr == ADDR_START) && (pwdata[TYPE_LSB +: 3] == TT_ANALOG)) begin
            compOwner_r <= TT_ANALOG; // [R17]
            compCond_r  <= pwdata[COND_LSB +: 2];
         end else if ((paddr == ADDR_STOP) && (pwdata[TYPE_LSB +: 3] == TT_ANALOG)) begin
            compOwner_r <= TT_ANALOG; // [R17]
            compCond_r  <= pwdata[COND_LSB +: 2];
         end else if ((paddr == ADDR_GATE) && (pwdata[TYPE_LSB +: 3] == TT_AGATE)) begin
            compOwner_r <= TT_AGATE; // [R17]
            compCond_r  <= COND_RISE;
         end else if ((paddr == ADDR_COMP) && pwdata[COMP_OUT_EN_BIT]) begin
            compOwner_r <= TT_ACOUT; // [R17]
            compCond_r  <= pwdata[COND_LSB +: 2];
         end
      end
   end

   // illegal configuration flag: a new error beats a same-cycle clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         illegal_r <= 1'b0;
      end else if (armWr && (state_r == ST_IDLE || state_r == ST_DONE) && cfgIllegal) begin
         illegal_r <= 1'b1;
      end else if (wrEn && (paddr == ADDR_STATUS) && pwdata[STAT_ILLEGAL_BIT]) begin
         illegal_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger sources and conditioning

   // fixed-pin parts feed both digital triggers from one pin
   assign digA     = singlePin_r ? externalTriggerPin : startTriggerPin; // [R20]
   assign digB     = singlePin_r ? externalTriggerPin : stopTriggerPin;  // [R20]
   assign digStart = (startType_r == TT_DIG_B) ? digB : digA; // [R1]
   assign digStop  = digA;

   aqtsq_edge_det #(
      .N (3)
   ) u_edges (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .sigIn   ({digStop, digStart, analogCompareIn}),
      .condIn  ({stopCond_r, startCond_r, compCond_r}),
      .edgeOut (edges)
   );

   assign compEv  = edges[0];
   assign startEv = (startType_r == TT_ANALOG) ? compEv : edges[1]; // [R1]
   assign stopEv  = (stopType_r == TT_ANALOG) ? compEv : edges[2];  // [R8]

   // comparator event routed out when the output user owns it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         compOut_r <= 1'b0;
      end else begin
         compOut_r <= compOutEn_r & (compOwner_r == TT_ACOUT) & compEv; // [R16]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode legality, evaluated when software arms

   assign pretrig        = (pre_r != 24'h00_0000);
   assign startLegalPost = (startType_r == TT_ANALOG) | (startType_r == TT_DIG_A); // [R3]
   assign stopLegal      = (stopType_r == TT_ANALOG) | (stopType_r == TT_DIG_A);   // [R8]
   assign startLegalHw   = (startType_r == TT_DIG_B) | (startType_r == TT_ANALOG); // [R8]
   always_comb begin
      if (!pretrig) begin
         cfgIllegal = ~startLegalPost; // [R3]
      end else begin
         cfgIllegal = (total_r <= pre_r) | ~stopLegal |
                      ~((startType_r == TT_NONE) | startLegalHw); // [R4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scan and channel clock, one shared clock that gating freezes

   assign running = (state_r == ST_PRE) || (state_r == ST_POST);
   always_comb begin
      if (gateType_r == TT_DGATE) begin
         gateOpen = externalScanGateInput; // [R13]
      end else if (gateType_r == TT_AGATE) begin
         gateOpen = analogCompareIn; // [R15]
      end else begin
         gateOpen = 1'b1;
      end
   end
   assign chanTick = running & gateOpen & (chanDiv_r == 16'h0000);
   assign scanTick = chanTick & (chanIdx_r >= chans_r - 8'h01);
   assign preFull  = (preHeld_r == pre_r);

   // divider and channel index hold while the gate is closed
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         chanDiv_r <= 16'h0000;
         chanIdx_r <= 8'h00;
      end else if (!running) begin
         chanDiv_r <= 16'h0000;
         chanIdx_r <= 8'h00;
      end else if (gateOpen) begin
         if (chanTick) begin
            chanDiv_r <= chanInterval_r - 16'h0001;
            chanIdx_r <= scanTick ? 8'h00 : chanIdx_r + 8'h01; // [R14]
         end else begin
            chanDiv_r <= chanDiv_r - 16'h0001;
         end
      end
   end

   // registered clock pulses toward the converter
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         chanPulse_r <= 1'b0;
         scanPulse_r <= 1'b0;
      end else begin
         chanPulse_r <= chanTick;
         scanPulse_r <= scanTick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // acquisition sequence

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r      <= ST_IDLE;
         postTarget_r <= 24'h00_0000;
      end else if (abortWr) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE, ST_DONE: begin
               if (armWr && !cfgIllegal) begin
                  if (!pretrig) begin
                     state_r      <= ST_WAIT_START; // [R2]
                     postTarget_r <= total_r;
                  end else if (startType_r == TT_NONE) begin
                     state_r <= ST_PRE; // [R6]
                  end else begin
                     state_r <= ST_WAIT_START; // [R7]
                  end
               end
            end
            ST_WAIT_START: begin
               if (startEv) begin
                  state_r <= pretrig ? ST_PRE : ST_POST; // [R2] [R7]
               end
            end
            ST_PRE: begin
               // stop accepted only once the pretrigger window is filled
               if (stopEv && preFull) begin
                  state_r      <= ST_POST; // [R5]
                  postTarget_r <= total_r - pre_r; // [R21]
               end
            end
            ST_POST: begin
               // zero total in posttrigger mode runs until abort
               if (scanTick && (postTarget_r != 24'h00_0000) &&
                   (postCnt_r + 24'h00_0001 == postTarget_r)) begin
                  state_r <= ST_DONE; // [R21]
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // scan counters
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         preHeld_r <= 24'h00_0000;
         postCnt_r <= 24'h00_0000;
         scanCnt_r <= 24'h00_0000;
         discard_r <= 24'h00_0000;
      end else if (armWr && (state_r == ST_IDLE || state_r == ST_DONE)) begin
         preHeld_r <= 24'h00_0000;
         postCnt_r <= 24'h00_0000;
         scanCnt_r <= 24'h00_0000;
         discard_r <= 24'h00_0000;
      end else if (scanTick) begin
         scanCnt_r <= scanCnt_r + 24'h00_0001;
         if (state_r == ST_PRE) begin
            if (preFull) begin
               discard_r <= discard_r + 24'h00_0001; // [R9]
            end else begin
               preHeld_r <= preHeld_r + 24'h00_0001; // [R4]
            end
         end else begin
            postCnt_r <= postCnt_r + 24'h00_0001; // [R21]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign compLevel                = compLevel_r;
   assign compWindow               = compWindow_r;
   assign dedicatedTriggerInputSel = dedicSel_r;
   assign comparatorEventOutput    = compOut_r;
   assign channelClockPulse        = chanPulse_r;
   assign scanClockPulse           = scanPulse_r;
   assign acquiring                = running;
   assign acqDone                  = (state_r == ST_DONE);

endmodule // aqtsq_sequencer

//--- verif/aqtsq_trig_src.sv
// trigger source model: digital pins, shared pin and comparator result
module aqtsq_trig_src (
   input  wire logic       clk_sys,
   input  wire logic [3:0] fire,
   output logic      [3:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;

   int hold [4];

   ////////////////////////////////////////////////////////////////////////////////
   // a request gives one high pulse of four cycles
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         if (fire[i]) begin
            hold[i] <= 4;
         end else if (hold[i] > 0) begin
            hold[i] <= hold[i] - 1;
         end
      end
   end

   // idle low; bit 2 is the one pin that carries start and stop in turn
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pins[i] = hold[i] > 0;
      end
   end
endmodule // aqtsq_trig_src

//--- verif/aqtsq_checker.sv
// port-level assertions for the acquisition trigger sequencer
module aqtsq_checker
   import aqtsq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        externalScanGateInput,
   input  wire logic [7:0]  compLevel,
   input  wire logic [7:0]  compWindow,
   input  wire logic        comparatorEventOutput,
   input  wire logic        channelClockPulse,
   input  wire logic        scanClockPulse,
   input  wire logic        acquiring,
   input  wire logic        acqDone
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   logic       wrEn, ctrlWr, compWr, compEn_r;
   logic [2:0] gateType_r;

   // writes commit at the first access edge
   assign wrEn   = psel && penable && pwrite;
   assign ctrlWr = wrEn && paddr == ADDR_CTRL;
   assign compWr = wrEn && paddr == ADDR_COMP;

   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the gate type, type 5 overwrites type 4
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gateType_r <= TT_NONE;
      end else if (wrEn && paddr == ADDR_GATE) begin
         gateType_r <= pwdata[2:0];
      end
   end

   // shadow of the comparator output enable
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         compEn_r <= 1'b0;
      end else if (compWr) begin
         compEn_r <= pwdata[COMP_OUT_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   AST_DONE_EXCL: assert property (!(acquiring && acqDone))
      else $error("done and acquiring together");
   AST_SCAN_CHAN: assert property (scanClockPulse |-> channelClockPulse)
      else $error("scan pulse without channel pulse");
   AST_PULSE_ACQ: assert property (channelClockPulse |-> $past(acquiring))
      else $error("channel pulse outside acquisition");
   // gate acts at once; four closed cycles in a row leave no channel pulse
   AST_GATE_HOLD: assert property ((gateType_r == TT_DGATE && !externalScanGateInput) [*4]
      |-> !channelClockPulse)
      else $error("channel clock ran with gate closed");
   AST_DONE_HOLD: assert property (acqDone && !ctrlWr |=> acqDone)
      else $error("done dropped without control write");
   AST_DONE_ENTRY: assert property ($rose(acqDone) |-> $past(acquiring))
      else $error("done without acquisition");
   AST_ACQ_FALL: assert property ($fell(acquiring) |-> acqDone || $past(ctrlWr))
      else $error("acquisition ended without stop or abort");
   AST_COMP_LVL: assert property (compWr |=> compLevel == $past(pwdata[15:8])
      && compWindow == $past(pwdata[23:16]))
      else $error("comparator setting not applied");
   AST_COMP_OUT: assert property (comparatorEventOutput |-> $past(compEn_r))
      else $error("comparator event while output disabled");

   COV_DONE: cover property ($rose(acqDone));
   COV_EVENT: cover property (comparatorEventOutput);
   COV_GATED: cover property (gateType_r == TT_DGATE && !externalScanGateInput && acquiring);
endmodule // aqtsq_checker

//--- verif/test_acquisition_trigger_sequencer.sv
// self-checking bench for the acquisition trigger sequencer
module test_acquisition_trigger_sequencer
   import aqtsq_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        gate    = 1'b1;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [3:0]  fire    = 4'h0;
   logic [3:0]  pins;
   logic [31:0] prdata, q;
   logic [7:0]  compLevel, compWindow;
   logic        pready, pslverr, e, dedicatedTriggerInputSel, comparatorEventOutput;
   logic        channelClockPulse, scanClockPulse, acquiring, acqDone;
   int          mismatches = 0, n_compared = 0, nScan = 0, nEv = 0, s0, pre, tot, k;

   // 20 MHz system clock
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   aqtsq_sequencer i_dut (.*, .startTriggerPin(pins[0]), .stopTriggerPin(pins[1]),
      .externalTriggerPin(pins[2]), .externalScanGateInput(gate), .analogCompareIn(pins[3]));
   aqtsq_trig_src i_src (.clk_sys(clk_sys), .fire(fire), .pins(pins));

   // tally of pulses, the observed scan and event counts from the dut
   always @(posedge clk_sys) begin
      nScan <= nScan + 32'(scanClockPulse === 1'b1);
      nEv   <= nEv + 32'(comparatorEventOutput === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, g, x);
      end
   endtask

   // one apb transfer; idle cycle first so no signal is driven twice per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys) penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 40);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) begin
         cmp(32'h0, 32'h1);
         final_report;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      cmp(q, x);
   endtask

   // expected status word: owner type, done flag, state code
   function automatic logic [31:0] stat(input int o, input int d, input int s);
      return 32'((o << STAT_OWNER_LSB) | (d << STAT_DONE_BIT) | s);
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic trig(input int i);
      @(posedge clk_sys) fire[i] <= 1'b1;
      @(posedge clk_sys) fire[i] <= 1'b0;
   endtask

   task automatic waitDone;
      int n;
      n = 0;
      while (acqDone !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 2000) begin
         cmp(32'h0, 32'h1);
         final_report;
      end
      cyc(3);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(23));
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(ADDR_TOTAL, 32'h0000_03E8);
      rd(ADDR_TIMING, 32'h0001_0004);
      rd(ADDR_STATUS, stat(0, 0, 0));
      apb(1'b0, 8'h30, 32'h0);
      cmp({31'h0, e}, 32'h1);
      // digital B cannot start a posttriggered run
      wr(ADDR_TIMING, 32'h0001_0001);
      wr(ADDR_START, 32'h13);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_STATUS, stat(0, 0, 0) | 32'h10);
      wr(ADDR_STATUS, 32'h10);
      rd(ADDR_STATUS, stat(0, 0, 0));
      wr(ADDR_COMP, 32'h0100_0000);
      // posttriggered runs, analog then digital A, random total
      for (k = 1; k < 3; k++) begin
         tot = 2 + $urandom % 4;
         wr(ADDR_TOTAL, 32'(tot));
         wr(ADDR_START, 32'h10 | 32'(k));
         wr(ADDR_CTRL, 32'h1);
         rd(ADDR_STATUS, stat(1, 0, 1));
         s0 = nScan;
         trig(k == 1 ? 3 : 0);
         waitDone;
         cmp(32'(nScan - s0), 32'(tot));
         rd(ADDR_SCANCNT, 32'(tot));
         rd(ADDR_STATUS, stat(1, 1, 4));
      end
      cmp({31'h0, dedicatedTriggerInputSel}, 32'h1);
      // zero total runs until aborted
      wr(ADDR_TOTAL, 32'h0);
      wr(ADDR_CTRL, 32'h1);
      trig(0);
      cyc(8);
      rd(ADDR_STATUS, stat(1, 0, 3));
      wr(ADDR_CTRL, 32'h2);
      rd(ADDR_STATUS, stat(1, 0, 0));
      // software start with gate freeze, stop while frozen
      pre = 2;
      tot = 5;
      wr(ADDR_PRE, 32'(pre));
      wr(ADDR_TOTAL, 32'(tot));
      wr(ADDR_TIMING, 32'h0002_0001);
      wr(ADDR_START, 32'h10);
      wr(ADDR_STOP, 32'h12);
      wr(ADDR_GATE, 32'(TT_DGATE));
      k = nScan;
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_STATUS, stat(1, 0, 2));
      cyc(10 + $urandom % 8);
      gate <= 1'b0;
      cyc(4);
      s0 = nScan;
      rd(ADDR_DISCARD, 32'(s0 - k - pre));
      cyc(8);
      cmp(32'(nScan), 32'(s0));
      trig(0);
      cyc(6);
      rd(ADDR_STATUS, stat(1, 0, 3));
      s0 = nScan;
      gate <= 1'b1;
      waitDone;
      cmp(32'(nScan - s0), 32'(tot - pre));
      wr(ADDR_GATE, 32'(TT_NONE));
      // hardware start on B, stop on A, then both on the shared pin
      wr(ADDR_PRE, 32'h1);
      wr(ADDR_TOTAL, 32'h3);
      wr(ADDR_START, 32'h13);
      for (k = 0; k < 2; k++) begin
         wr(ADDR_PINCFG, 32'(k));
         wr(ADDR_CTRL, 32'h1);
         trig(k == 0 ? 0 : 3);
         rd(ADDR_STATUS, stat(1, 0, 1));
         trig(k == 0 ? 1 : 2);
         cyc(10);
         rd(ADDR_STATUS, stat(1, 0, 2));
         trig(k == 0 ? 0 : 2);
         waitDone;
         rd(ADDR_STATUS, stat(1, 1, 4));
      end
      // comparator shared by types 1, 5 and 6
      wr(ADDR_COMP, 32'h0120_3311);
      rd(ADDR_COMP, 32'h0120_3311);
      rd(ADDR_STATUS, stat(6, 1, 4));
      s0 = nEv;
      trig(3);
      cyc(6);
      cmp(32'(nEv - s0), 32'h1);
      wr(ADDR_GATE, 32'(TT_AGATE));
      rd(ADDR_STATUS, stat(5, 1, 4));
      s0 = nEv;
      trig(3);
      cyc(6);
      cmp(32'(nEv - s0), 32'h0);
      wr(ADDR_START, 32'h11);
      rd(ADDR_STATUS, stat(1, 1, 4));
      final_report;
   end
endmodule // test_acquisition_trigger_sequencer

bind aqtsq_sequencer aqtsq_checker i_chk (.*);
